//--- verification/imt_master_tx_props.sv
`timescale 1ns/1ps
module imt_master_tx_props (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic [4:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic                  avs_waitrequest,
    input wire logic                  irq,
    input wire imt_pkg::imt_pins_type pin_oe_n
);
    import imt_pkg::*;

    logic [7:0]  baud_q;
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    logic        dat_q;
    logic        clr_q;
    logic        acc;
    logic [15:0] per;

    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign per = {8'h00, baud_q} + 16'h0001;

    // ********************
    // Helper state
    // ********************
    // Mirror of the reload value, so the high phase length is checked exactly
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_q <= BAUD_RESET;
        end else if (acc && avs_write && avs_address == ADDR_BAUD) begin
            baud_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= acc && (avs_read ? avs_address == ADDR_IRQ_ST
                                      : avs_address == ADDR_IRQ_MK);
        end
    end

    // High count restarts on a data edge: start and restart space from it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_q  <= 16'h0000;
            lo_q  <= 16'h0000;
            dat_q <= 1'b1;
        end else begin
            dat_q <= pin_oe_n.data_line;
            if (pin_oe_n.clock_line) begin
                lo_q <= 16'h0000;
                hi_q <= (pin_oe_n.data_line != dat_q) ? 16'h0001
                        : hi_q + {15'h0000, ~&hi_q};
            end else begin
                hi_q <= 16'h0000;
                lo_q <= lo_q + {15'h0000, ~&lo_q};
            end
        end
    end

    // ********************
    // Assertions
    // ********************
    chk_wait_once: assert property (
        @(posedge clk) disable iff (!resetn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
    chk_wait_first: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("bus request answered without a wait");
    chk_high_phase: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(pin_oe_n.clock_line) |-> hi_q == per)
        else $error("clock high phase length wrong");
    chk_low_phase: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(pin_oe_n.clock_line) |-> lo_q >= per)
        else $error("clock low phase too short");
    chk_data_hold: assert property (
        @(posedge clk) disable iff (!resetn)
        $changed(pin_oe_n.data_line) && !pin_oe_n.clock_line
        |-> lo_q >= 16'(HOLD_CYC))
        else $error("data changed inside hold time");
    chk_start_space: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(pin_oe_n.data_line) && pin_oe_n.clock_line
        |=> pin_oe_n.clock_line [*8])
        else $error("clock fell too soon after start");
    chk_stop_cond: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(pin_oe_n.data_line) && pin_oe_n.clock_line
        |=> (pin_oe_n.clock_line && pin_oe_n.data_line) [*8])
        else $error("lines not idle after stop");
    chk_irq_clear: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(irq) |-> clr_q)
        else $error("interrupt dropped without a clearing access");
endmodule

bind imt_master_tx imt_master_tx_props u_props (
    .clk             (clk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .pin_oe_n        (pin_oe_n)
);

//--- verification/imt_slave_model.sv
`timescale 1ns/1ps
module imt_slave_model (
    input  wire logic   scl,
    input  wire logic   sda,
    input  wire logic   ack_en,
    output logic        sda_low,
    output logic [7:0]  rx_byte,
    output logic [15:0] rx_count
);
    int         bit_n;
    logic       active;
    logic [7:0] shift;

    initial begin
        sda_low  = 1'b0;
        rx_byte  = 8'h00;
        rx_count = 16'h0000;
        active   = 1'b0;
        bit_n    = 0;
        shift    = 8'h00;
    end

    // Start or repeated start restarts the bit count
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            bit_n  = 0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
        end
    end

    always @(posedge scl) begin
        if (active) begin
            if (bit_n < 8) begin
                shift = {shift[6:0], sda};
            end
            bit_n = bit_n + 1;
            if (bit_n == 8) begin
                rx_byte  = shift;
                rx_count = rx_count + 16'h0001;
            end
            if (bit_n == 9) begin
                bit_n = 0;
            end
        end
    end

    // Pulls only for the ninth bit; a silent slave leaves the pull-up
    always @(negedge scl) begin
        sda_low = active && (bit_n == 8) && ack_en;
    end
endmodule

//--- verification/tb_imt_master_tx.sv
`timescale 1ns/1ps
module tb_imt_master_tx;
    import imt_pkg::*;

    logic         clk;
    logic         resetn;
    logic [4:0]   avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         irq;
    imt_pins_type pin_in;
    imt_pins_type pin_out;
    imt_pins_type pin_oe_n;
    logic         sda_low;
    logic         ack_en;
    logic [7:0]   rx_byte;
    logic [15:0]  rx_count;
    logic [31:0]  lfsr_q;
    logic [7:0]   tx;
    logic [63:0]  note;
    logic [63:0]  note_q[$];
    logic [7:0]   byte_q[$];
    int           fails;
    int           cmp_count;

    // Open drain with pull-ups: low if either party pulls
    assign pin_in.clock_line = pin_oe_n.clock_line;
    assign pin_in.data_line  = pin_oe_n.data_line & ~sda_low;

    imt_master_tx DUT (
        .clk             (clk),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq             (irq),
        .pin_in          (pin_in),
        .pin_out         (pin_out),
        .pin_oe_n        (pin_oe_n)
    );

    imt_slave_model u_slave (
        .scl      (pin_in.clock_line),
        .sda      (pin_in.data_line),
        .ack_en   (ack_en),
        .sda_low  (sda_low),
        .rx_byte  (rx_byte),
        .rx_count (rx_count)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ********************
    // Tasks
    // ********************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n == 50) begin
            fails++;
            give_verdict();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic expect_rd(input logic [4:0] a, input logic [31:0] e,
                             input logic [31:0] m);
        logic [31:0] q;
        note_q.push_back({m, e});
        bus(1'b0, a, 32'h0, q);
    endtask

    // Polls until the event shows, then reads and clears it
    task automatic wait_done(input logic [31:0] ev, input logic irq_exp);
        int n;
        logic [31:0] q;
        n = 0;
        q = 32'h0;
        while (irq !== 1'b1 && q[ST_IRQF] !== 1'b1 && n < 5000) begin
            bus(1'b0, ADDR_STATUS, 32'h0, q);
            n++;
        end
        if (n == 5000) begin
            fails++;
            give_verdict();
        end
        check({31'h0, irq}, {31'h0, irq_exp});
        expect_rd(ADDR_IRQ_ST, ev, 32'hF);
        wr(ADDR_STATUS, 32'h8);
        check({31'h0, irq}, 32'h0);
    endtask

    // ********************
    // Result monitors
    // ********************
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && note_q.size() > 0) begin
            note = note_q.pop_front();
            check(avs_readdata & note[63:32], note[31:0]);
        end
    end

    always @(rx_count) begin
        if (byte_q.size() > 0) begin
            check({24'h0, rx_byte}, {24'h0, byte_q.pop_front()});
        end
    end

    // ********************
    // Sequence
    // ********************
    initial begin
        resetn        = 1'b0;
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        ack_en        = 1'b1;
        lfsr_q        = 32'h7EBE3BFC;
        fails         = 0;
        cmp_count     = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        expect_rd(ADDR_BAUD, {24'h0, BAUD_RESET}, 32'hFF);
        expect_rd(ADDR_IRQ_MK, 32'h0, 32'hFFFFFFFF);
        expect_rd(ADDR_STATUS, 32'h0, 32'h1F);
        expect_rd(5'h18, 32'h0, 32'hFFFFFFFF);
        // Random reload from 0x0C to 0x13, so the hold still fits in the low phase
        lfsr_q = lfsr_next(lfsr_q);
        tx = 8'h0C + {5'h00, lfsr_q[2:0]};
        wr(ADDR_BAUD, {24'h0, tx});
        expect_rd(ADDR_BAUD, {24'h0, tx}, 32'hFF);
        $display("test registers done");
        wr(ADDR_CTRL, 32'h1);
        wait_done(32'h1, 1'b0);
        expect_rd(ADDR_CTRL, 32'h0, 32'h7);
        $display("test masked start done");
        wr(ADDR_IRQ_MK, 32'hF);
        tx = {lfsr_q[9:3], 1'b0};
        byte_q.push_back(tx);
        wr(ADDR_TXBUF, {24'h0, tx});
        expect_rd(ADDR_STATUS, 32'h11, 32'h11);
        wr(ADDR_TXBUF, {24'h0, ~tx});
        expect_rd(ADDR_IRQ_ST, 32'h8, 32'hF);
        expect_rd(ADDR_TXBUF, {24'h0, tx}, 32'hFF);
        expect_rd(ADDR_STATUS, 32'h4, 32'h4);
        wr(ADDR_STATUS, 32'h4);
        wait_done(32'h2, 1'b1);
        expect_rd(ADDR_STATUS, 32'h0, 32'h7);
        check({31'h0, pin_in.clock_line}, 32'h0);
        check({31'h0, pin_oe_n.data_line}, 32'h1);
        $display("test address byte done");
        for (int i = 0; i < 2; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            tx = lfsr_q[7:0];
            ack_en <= (i == 0);
            byte_q.push_back(tx);
            wr(ADDR_TXBUF, {24'h0, tx});
            wait_done(32'h2, 1'b1);
            expect_rd(ADDR_STATUS, {30'h0, 1'(i), 1'b0}, 32'h3);
        end
        $display("test data bytes done");
        for (int i = 1; i < 3; i++) begin
            wr(ADDR_CTRL, 32'h1 << i);
            expect_rd(ADDR_CTRL, 32'h1 << i, 32'h7);
            wait_done(32'h4, 1'b1);
            expect_rd(ADDR_CTRL, 32'h0, 32'h7);
        end
        expect_rd(ADDR_STATUS, 32'h0, 32'h10);
        check({30'h0, pin_in}, 32'h3);
        check({30'h0, pin_out}, 32'h0);
        check({16'h0, rx_count}, 32'h3);
        $display("test restart and stop done");
        give_verdict();
    end
endmodule

//--- verilog/imt_baud_gen.sv
`timescale 1ns/1ps
module imt_baud_gen (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [7:0] reload,
    output logic            tick
);
    import imt_pkg::*;

    logic [7:0] cnt_q;

    // Stopped generator sits at the reload value, so each run starts
    // with a full rollover period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
        end else if (!run || cnt_q == 8'h00) begin
            cnt_q <= reload;
        end else begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign tick = run && cnt_q == 8'h00;
endmodule

//--- verilog/imt_master_tx.sv
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
module imt_master_tx (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    output logic                       irq,
    input  wire imt_pkg::imt_pins_type pin_in,
    output imt_pkg::imt_pins_type      pin_out,
    output imt_pkg::imt_pins_type      pin_oe_n
);
    import imt_pkg::*;

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    imt_pins_type  meta_q;
    imt_pins_type  sync_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '{clock_line: 1'b1, data_line: 1'b1};
            sync_q <= '{clock_line: 1'b1, data_line: 1'b1};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    // ***************************************************************
    // Bus slave
    // ***************************************************************
    logic             ack_q;
    logic             req;
    logic             wr_go;
    logic             rd_go;
    logic [7:0]       tx_buffer_q;
    logic [7:0]       baud_q;
    logic [2:0]       ctrl_q;
    logic             buffer_full_flag_q;
    logic             ack_status_bit_q;
    logic             write_collision_flag_q;
    logic             port_irq_flag_q;
    logic [EV_W-1:0]  irq_st_q;
    logic [EV_W-1:0]  irq_mk_q;
    logic [EV_W-1:0]  ev;
    imt_state_type    state_q;
    logic             busy;

    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign wr_go           = avs_write && ack_q;
    assign rd_go           = avs_read && ack_q;
    assign busy            = state_q != S_IDLE;

    function automatic logic hit(input logic [4:0] a);
        return avs_address == a;
    endfunction

    // One wait cycle per access, read data stands at the accept edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h00000000;
        end else if (req && !ack_q) begin
            unique case (avs_address)
                ADDR_TXBUF:  avs_readdata <= {24'h000000, tx_buffer_q};
                ADDR_CTRL:   avs_readdata <= {29'h00000000, ctrl_q};
                ADDR_STATUS: avs_readdata <= {27'h0000000, busy,
                    port_irq_flag_q, write_collision_flag_q,
                    ack_status_bit_q, buffer_full_flag_q};
                ADDR_IRQ_ST: avs_readdata <= {28'h0000000, irq_st_q};
                ADDR_IRQ_MK: avs_readdata <= {28'h0000000, irq_mk_q};
                ADDR_BAUD:   avs_readdata <= {24'h000000, baud_q};
                default:     avs_readdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_q   <= BAUD_RESET;
            irq_mk_q <= MASK_RESET;
        end else if (wr_go && hit(ADDR_BAUD)) begin
            baud_q <= avs_writedata[7:0];
        end else if (wr_go && hit(ADDR_IRQ_MK)) begin
            irq_mk_q <= avs_writedata[EV_W-1:0];
        end
    end

    // ***************************************************************
    // Interrupt status, cleared by reading, a new event wins
    // ***************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_st_q <= '0;
        end else if (rd_go && hit(ADDR_IRQ_ST)) begin
            irq_st_q <= (irq_st_q & ~avs_readdata[EV_W-1:0]) | ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
    end

    assign irq = |(irq_st_q & irq_mk_q);

    // ***************************************************************
    // Bus sequencer
    // ***************************************************************
    logic         tick;
    logic [1:0]   phase_q;
    logic [3:0]   bit_cnt_q;
    logic [3:0]   hold_q;
    logic [7:0]   shift_register_q;
    logic         drv_scl_q;
    logic         drv_sda_q;
    logic         buf_wr;
    logic         done;

    // Baud generator runs only while a sequence is under way
    imt_baud_gen u_baud (
        .clk    (clk),
        .resetn (resetn),
        .run    (busy),
        .reload (baud_q),
        .tick   (tick)
    );

    assign buf_wr = wr_go && hit(ADDR_TXBUF);
    assign done   = tick && ((state_q == S_HIGH && bit_cnt_q == LAST_BIT)
                    || (state_q == S_START && phase_q == 2'd1)
                    || (state_q == S_RESTART && phase_q == 2'd3)
                    || (state_q == S_STOP && phase_q == 2'd2));

    always_comb begin
        ev           = '0;
        ev[EV_START] = done && state_q == S_START;
        ev[EV_BYTE]  = done && state_q == S_HIGH;
        ev[EV_END]   = done && (state_q == S_STOP
                       || state_q == S_RESTART);
        ev[EV_WRITE_COLLISION_FLAG]  = buf_wr && busy;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= S_IDLE;
            phase_q   <= 2'd0;
            bit_cnt_q <= 4'h0;
            ctrl_q    <= 3'b000;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    phase_q <= 2'd0;
                    if (buf_wr) begin
                        state_q   <= S_LOW;
                        bit_cnt_q <= 4'h0;
                    end else if (wr_go && hit(ADDR_CTRL)) begin
                        ctrl_q <= avs_writedata[2:0];
                        if (avs_writedata[CTRL_START]) begin
                            state_q <= S_START;
                        end else if (avs_writedata[CTRL_RESTART]) begin
                            state_q <= S_RESTART;
                        end else if (avs_writedata[CTRL_STOP]) begin
                            state_q <= S_STOP;
                        end
                    end
                end
                S_START, S_RESTART, S_STOP: begin
                    if (done) begin
                        state_q <= S_IDLE;
                        ctrl_q  <= 3'b000;
                    end else if (tick) begin
                        phase_q <= phase_q + 2'd1;
                    end
                end
                S_LOW: begin
                    if (tick) begin
                        state_q <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (done) begin
                        state_q <= S_IDLE;
                    end else if (tick) begin
                        state_q   <= S_LOW;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Data changes only after the hold count following a clock fall
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 4'h0;
        end else if (state_q != S_LOW) begin
            hold_q <= 4'h0;
        end else if (hold_q != HOLD_CYC_W) begin
            hold_q <= hold_q + 4'h1;
        end
    end

    // ***************************************************************
    // Line drivers, a one means pull low
    // ***************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv_scl_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_START: begin
                    if (tick && phase_q == 2'd0) begin
                        drv_scl_q <= 1'b1;
                    end
                end
                S_RESTART: begin
                    if (tick && phase_q == 2'd0) begin
                        drv_scl_q <= 1'b0;
                    end else if (tick && phase_q == 2'd2) begin
                        drv_scl_q <= 1'b1;
                    end
                end
                S_STOP: begin
                    if (tick && phase_q == 2'd0) begin
                        drv_scl_q <= 1'b0;
                    end
                end
                S_LOW: begin
                    drv_scl_q <= !tick;
                end
                S_HIGH: begin
                    drv_scl_q <= tick;
                end
                default: begin
                    drv_scl_q <= drv_scl_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv_sda_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_START: begin
                    drv_sda_q <= 1'b1;
                end
                S_RESTART: begin
                    if (phase_q == 2'd0) begin
                        drv_sda_q <= 1'b0;
                    end else if (tick && phase_q == 2'd1) begin
                        drv_sda_q <= 1'b1;
                    end
                end
                S_STOP: begin
                    if (phase_q == 2'd0) begin
                        drv_sda_q <= 1'b1;
                    end else if (tick && phase_q == 2'd1) begin
                        drv_sda_q <= 1'b0;
                    end
                end
                S_LOW: begin
                    if (hold_q == HOLD_CYC_W - 4'h1) begin
                        // Ninth bit leaves the line to the slave
                        drv_sda_q <= bit_cnt_q != LAST_BIT
                            && !shift_register_q[7];
                    end
                end
                default: begin
                    drv_sda_q <= drv_sda_q || (!busy && wr_go
                        && hit(ADDR_CTRL) && avs_writedata[CTRL_START]);
                end
            endcase
        end
    end

    assign pin_out.clock_line  = 1'b0;
    assign pin_out.data_line   = 1'b0;
    assign pin_oe_n.clock_line = !drv_scl_q;
    assign pin_oe_n.data_line  = !drv_sda_q;

    // ***************************************************************
    // Buffer, shift register and flags
    // ***************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_buffer_q      <= 8'h00;
            shift_register_q <= 8'h00;
        end else if (buf_wr && !busy) begin
            tx_buffer_q      <= avs_writedata[7:0];
            shift_register_q <= avs_writedata[7:0];
        end else if (state_q == S_HIGH && tick) begin
            shift_register_q <= {shift_register_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            buffer_full_flag_q <= 1'b0;
        end else if (buf_wr && !busy) begin
            buffer_full_flag_q <= 1'b1;
        end else if (state_q == S_HIGH && tick
                     && bit_cnt_q == LAST_BIT - 4'h1) begin
            buffer_full_flag_q <= 1'b0;
        end
    end

    // Synced line lags the pin two cycles, well inside the high phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_status_bit_q <= 1'b0;
        end else if (done && state_q == S_HIGH) begin
            ack_status_bit_q <= sync_q.data_line;
        end
    end

    // Write-one-to-clear; a new collision in the same cycle wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            write_collision_flag_q <= 1'b0;
        end else if (buf_wr && busy) begin
            write_collision_flag_q <= 1'b1;
        end else if (wr_go && hit(ADDR_STATUS)
                     && avs_writedata[ST_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port_irq_flag_q <= 1'b0;
        end else if (done) begin
            port_irq_flag_q <= 1'b1;
        end else if (wr_go && hit(ADDR_STATUS)
                     && avs_writedata[ST_IRQF]) begin
            port_irq_flag_q <= 1'b0;
        end
    end
endmodule

//--- verilog/imt_pkg.sv
package imt_pkg;

    // ***************************************************************
    // Register map, byte addresses
    // ***************************************************************
    localparam logic [4:0] ADDR_TXBUF  = 5'h00;
    localparam logic [4:0] ADDR_CTRL   = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_ST = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_MK = 5'h10;
    localparam logic [4:0] ADDR_BAUD   = 5'h14;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int CTRL_START   = 0;
    localparam int CTRL_RESTART = 1;
    localparam int CTRL_STOP    = 2;
    localparam int ST_BF        = 0;
    localparam int ST_ACK       = 1;
    localparam int ST_WRITE_COLLISION_FLAG      = 2;
    localparam int ST_IRQF      = 3;
    localparam int ST_BUSY      = 4;
    localparam int EV_START     = 0;
    localparam int EV_BYTE      = 1;
    localparam int EV_END       = 2;
    localparam int EV_WRITE_COLLISION_FLAG      = 3;
    localparam int EV_W         = 4;

    // ***************************************************************
    // Reset values and timing
    // ***************************************************************
    localparam logic [7:0]      BAUD_RESET  = 8'h13;
    localparam logic [EV_W-1:0] MASK_RESET  = 4'h0;
    localparam int CLK_PERIOD_NS = 25;
    localparam int HOLD_TIME_NS  = 300;
    // Least time, so round up
    localparam int HOLD_CYC =
        (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOLD_CYC_W = 4'(HOLD_CYC);
    localparam logic [3:0] LAST_BIT   = 4'h8;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef struct packed {
        logic clock_line;
        logic data_line;
    } imt_pins_type;

    typedef enum logic [5:0] {
        S_IDLE    = 6'b000001,
        S_START   = 6'b000010,
        S_RESTART = 6'b000100,
        S_STOP    = 6'b001000,
        S_LOW     = 6'b010000,
        S_HIGH    = 6'b100000
    } imt_state_type;

endpackage
